// >>> hw/esr_status_top.sv
// esr_status_top: status byte of the video encoder and its two-wire read slave
// assumes: encoder event inputs are on clk; scl/sda come from pins; lclk oversamples the link
`timescale 1ns/1ns
// Behaviour
// - answer read address with status byte
// - top three bits carry version identifier
// - odd caption done sets after encoding
// - odd caption done clears after caption write
// - even caption done sets after encoding
// - even caption done clears after caption write
// - unused bit always reads zero
// - sequence bit high in first field only
// - parity bit high during even field
module esr_status_top
  import esr_pkg::*;
#(
  parameter logic [2:0] VERSION_ID = ESR_VERSION_DEF
)
(
  // clocks and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       lclk,
  // encoder timing
  input  wire logic       field_start,
  input  wire logic       field_is_even,
  input  wire logic [1:0] video_std,
  // caption events
  input  wire logic       odd_cc_encoded,
  input  wire logic       even_cc_encoded,
  input  wire logic       odd_cc_written,
  input  wire logic       even_cc_written,
  // two-wire link
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // status view
  output logic [7:0]      status_byte
);

  // clk domain state
  logic       srst_n_meta_ff;
  logic       srst_n_ff;
  logic       odd_caption_done_ff;
  logic       nxt_odd_caption_done;
  logic       even_caption_done_ff;
  logic       nxt_even_caption_done;
  logic [3:0] field_cnt_ff;
  logic [3:0] nxt_field_cnt;
  logic [3:0] seq_len;
  logic       colour_sequence_first_field_ff;
  logic       nxt_colour_sequence_first_field;
  logic       even_field_ff;
  logic       nxt_even_field;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;

  // lclk domain state
  logic       lrst_n_meta_ff;
  logic       lrst_n_ff;
  logic       scl_meta_ff;
  logic       scl_sync_ff;
  logic       scl_prev_ff;
  logic       sda_meta_ff;
  logic       sda_sync_ff;
  logic       sda_prev_ff;
  esr_link_t  state_ff;
  esr_link_t  nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic       drive_low_ff;
  logic       nxt_drive_low;
  logic       master_ack_ff;
  logic       nxt_master_ack;
  logic [7:0] link_status;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;

  // reset release for clk, async assert
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      srst_n_meta_ff <= 1'b0;
      srst_n_ff      <= 1'b0;
    end
    else
    begin
      srst_n_meta_ff <= 1'b1;
      srst_n_ff      <= srst_n_meta_ff;
    end
  end

  // reset release for lclk, async assert
  always_ff @(posedge lclk or negedge nrst)
  begin
    if (!nrst)
    begin
      lrst_n_meta_ff <= 1'b0;
      lrst_n_ff      <= 1'b0;
    end
    else
    begin
      lrst_n_meta_ff <= 1'b1;
      lrst_n_ff      <= lrst_n_meta_ff;
    end
  end

  // caption flags: set wins over clear
  always_comb
  begin
    nxt_odd_caption_done  = odd_caption_done_ff;
    nxt_even_caption_done = even_caption_done_ff;
    if (odd_cc_encoded)
      nxt_odd_caption_done = 1'b1;
    else if (odd_cc_written)
      nxt_odd_caption_done = 1'b0;
    if (even_cc_encoded)
      nxt_even_caption_done = 1'b1;
    else if (even_cc_written)
      nxt_even_caption_done = 1'b0;
  end

  // colour sequence length per standard
  always_comb
  begin
    unique case (video_std)
      ESR_STD_PAL:   seq_len = ESR_SEQ_PAL;
      ESR_STD_SECAM: seq_len = ESR_SEQ_SECAM;
      ESR_STD_NTSC:  seq_len = ESR_SEQ_NTSC;
      default:       seq_len = ESR_SEQ_NTSC; // illegal code falls back
    endcase
  end

  // field counter, sequence and parity indicators
  always_comb
  begin
    nxt_field_cnt = field_cnt_ff;
    if (field_start)
    begin
      if (field_cnt_ff >= seq_len - 4'h1)
        nxt_field_cnt = ESR_CNT_RST;
      else
        nxt_field_cnt = field_cnt_ff + 4'h1;
    end
    nxt_colour_sequence_first_field = (field_cnt_ff == ESR_CNT_RST);
    nxt_even_field                  = field_is_even;
  end

  // status byte assembly
  always_comb
  begin
    nxt_status                            = ESR_STATUS_RST;
    nxt_status[ESR_VER_MSB:ESR_VER_LSB]   = VERSION_ID;
    nxt_status[ESR_ODD_DONE_BIT]          = odd_caption_done_ff;
    nxt_status[ESR_EVEN_DONE_BIT]         = even_caption_done_ff;
    nxt_status[ESR_UNUSED_BIT]            = ESR_UNUSED_VAL;
    nxt_status[ESR_COLOUR_SEQUENCE_FIRST_FIELD_BIT]              = colour_sequence_first_field_ff;
    nxt_status[ESR_PARITY_BIT]            = even_field_ff;
  end

  // clk domain registers
  always_ff @(posedge clk or negedge srst_n_ff)
  begin
    if (!srst_n_ff)
    begin
      odd_caption_done_ff            <= ESR_FLAG_RST;
      even_caption_done_ff           <= ESR_FLAG_RST;
      field_cnt_ff                   <= ESR_CNT_RST;
      colour_sequence_first_field_ff <= ESR_FLAG_RST;
      even_field_ff                  <= ESR_FLAG_RST;
      status_ff                      <= ESR_STATUS_RST;
    end
    else
    begin
      odd_caption_done_ff            <= nxt_odd_caption_done;
      even_caption_done_ff           <= nxt_even_caption_done;
      field_cnt_ff                   <= nxt_field_cnt;
      colour_sequence_first_field_ff <= nxt_colour_sequence_first_field;
      even_field_ff                  <= nxt_even_field;
      status_ff                      <= nxt_status;
    end
  end

  assign status_byte = status_ff;

  // status word into the link domain
  esr_word_xfer #(
    .W (8)
  ) u_xfer (
    .src_clk   (clk),
    .src_rst_n (srst_n_ff),
    .src_word  (status_ff),
    .dst_clk   (lclk),
    .dst_rst_n (lrst_n_ff),
    .dst_word  (link_status)
  );

  // pin synchronisers and previous samples
  always_ff @(posedge lclk or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else
    begin
      scl_meta_ff <= scl_i;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= sda_i;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  // bus conditions from synchronised samples
  assign scl_rise   = scl_sync_ff & ~scl_prev_ff;
  assign scl_fall   = ~scl_sync_ff & scl_prev_ff;
  assign start_seen = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
  assign stop_seen  = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

  // slave transmitter sequencing
  always_comb
  begin
    nxt_state      = state_ff;
    nxt_bit_cnt    = bit_cnt_ff;
    nxt_shift      = shift_ff;
    nxt_drive_low  = drive_low_ff;
    nxt_master_ack = master_ack_ff;
    if (start_seen)
    begin
      nxt_state     = ESR_ADDR; // repeated start also restarts
      nxt_bit_cnt   = ESR_CNT_RST;
      nxt_drive_low = 1'b0;
    end
    else if (stop_seen)
    begin
      nxt_state     = ESR_IDLE;
      nxt_drive_low = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ESR_IDLE:
        begin
          nxt_drive_low = 1'b0;
        end
        ESR_ADDR:
        begin
          if (scl_rise)
          begin
            nxt_shift   = {shift_ff[6:0], sda_sync_ff};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
          else if (scl_fall && bit_cnt_ff == ESR_BITS_PER_BYTE)
          begin
            if (shift_ff == ESR_RD_ADDR)
            begin
              nxt_state     = ESR_AACK;
              nxt_drive_low = 1'b1;
            end
            else
            begin
              nxt_state = ESR_IDLE; // other addresses left alone
            end
          end
        end
        ESR_AACK:
        begin
          if (scl_fall)
          begin
            nxt_shift     = link_status;
            nxt_drive_low = ~link_status[7];
            nxt_bit_cnt   = ESR_CNT_RST;
            nxt_state     = ESR_TX;
          end
        end
        ESR_TX:
        begin
          if (scl_rise)
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          else if (scl_fall)
          begin
            if (bit_cnt_ff == ESR_BITS_PER_BYTE)
            begin
              nxt_drive_low = 1'b0; // release for master ack
              nxt_state     = ESR_MACK;
            end
            else
            begin
              nxt_shift     = {shift_ff[6:0], 1'b0};
              nxt_drive_low = ~shift_ff[6];
            end
          end
        end
        ESR_MACK:
        begin
          if (scl_rise)
            nxt_master_ack = ~sda_sync_ff;
          else if (scl_fall)
          begin
            if (master_ack_ff)
            begin
              nxt_shift     = link_status; // ack: send fresh status again
              nxt_drive_low = ~link_status[7];
              nxt_bit_cnt   = ESR_CNT_RST;
              nxt_state     = ESR_TX;
            end
            else
            begin
              nxt_state = ESR_IDLE;
            end
          end
        end
      endcase
    end
  end

  // link domain registers
  always_ff @(posedge lclk or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      state_ff      <= ESR_IDLE;
      bit_cnt_ff    <= ESR_CNT_RST;
      shift_ff      <= ESR_STATUS_RST;
      drive_low_ff  <= 1'b0;
      master_ack_ff <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      bit_cnt_ff    <= nxt_bit_cnt;
      shift_ff      <= nxt_shift;
      drive_low_ff  <= nxt_drive_low;
      master_ack_ff <= nxt_master_ack;
    end
  end

  // open drain: only ever pull low
  assign sda_oe = drive_low_ff;
  assign sda_o  = 1'b0;

endmodule

// >>> hw/esr_word_xfer.sv
// esr_word_xfer: moves a word from one clock domain to another by toggle handshake
// assumes: both resets already synchronised to their own clocks
`timescale 1ns/1ns
module esr_word_xfer
  import esr_pkg::*;
#(
  parameter int W = 8
)
(
  // source side
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic [W-1:0] src_word,
  // destination side
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic      [W-1:0] dst_word
);

  logic         req_ff;
  logic         nxt_req;
  logic [W-1:0] hold_ff;
  logic [W-1:0] nxt_hold;
  logic         ack_meta_ff;
  logic         ack_sync_ff;
  logic         req_meta_ff;
  logic         req_sync_ff;
  logic         ack_ff;
  logic         nxt_ack;
  logic [W-1:0] word_ff;
  logic [W-1:0] nxt_word;

  // source: take a new sample once the last one was acknowledged
  always_comb
  begin
    nxt_req  = req_ff;
    nxt_hold = hold_ff;
    if (ack_sync_ff == req_ff)
    begin
      nxt_hold = src_word;
      nxt_req  = ~req_ff;
    end
  end

  always_ff @(posedge src_clk or negedge src_rst_n)
  begin
    if (!src_rst_n)
    begin
      req_ff      <= 1'b0;
      hold_ff     <= '0;
      ack_meta_ff <= 1'b0;
      ack_sync_ff <= 1'b0;
    end
    else
    begin
      req_ff      <= nxt_req;
      hold_ff     <= nxt_hold;
      ack_meta_ff <= ack_ff;
      ack_sync_ff <= ack_meta_ff;
    end
  end

  // destination: hold word is stable while request and ack differ
  always_comb
  begin
    nxt_ack  = ack_ff;
    nxt_word = word_ff;
    if (req_sync_ff != ack_ff)
    begin
      nxt_word = hold_ff;
      nxt_ack  = req_sync_ff;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n)
  begin
    if (!dst_rst_n)
    begin
      req_meta_ff <= 1'b0;
      req_sync_ff <= 1'b0;
      ack_ff      <= 1'b0;
      word_ff     <= '0;
    end
    else
    begin
      req_meta_ff <= req_ff;
      req_sync_ff <= req_meta_ff;
      ack_ff      <= nxt_ack;
      word_ff     <= nxt_word;
    end
  end

  assign dst_word = word_ff;

endmodule

// >>> pkg/esr_pkg.sv
// esr_pkg: constants and types for the encoder status readback block
// assumes: shared by the status top and its word crossing; no tool switches needed
package esr_pkg;

  // two-wire slave address that selects the status read
  localparam logic [7:0] ESR_RD_ADDR       = 8'h89;
  // register offset of the status byte
  localparam logic [7:0] ESR_STATUS_OFS    = 8'h00;

  // status byte field positions
  localparam int         ESR_VER_MSB       = 7;
  localparam int         ESR_VER_LSB       = 5;
  localparam int         ESR_ODD_DONE_BIT  = 4;
  localparam int         ESR_EVEN_DONE_BIT = 3;
  localparam int         ESR_UNUSED_BIT    = 2;
  localparam int         ESR_COLOUR_SEQUENCE_FIRST_FIELD_BIT      = 1;
  localparam int         ESR_PARITY_BIT    = 0;

  // version identifier default; value is arbitrary
  localparam logic [2:0] ESR_VERSION_DEF   = 3'h5;
  // value returned in the unused status position
  localparam logic       ESR_UNUSED_VAL    = 1'b0;
  // reset values
  localparam logic       ESR_FLAG_RST      = 1'b0;
  localparam logic [7:0] ESR_STATUS_RST    = 8'h00;
  localparam logic [3:0] ESR_CNT_RST       = 4'h0;

  // colour sequence length in fields per standard
  localparam logic [3:0] ESR_SEQ_NTSC      = 4'h4;
  localparam logic [3:0] ESR_SEQ_PAL       = 4'h8;
  localparam logic [3:0] ESR_SEQ_SECAM     = 4'hc;

  // bits in one byte on the link
  localparam logic [3:0] ESR_BITS_PER_BYTE = 4'h8;

  // video standard select
  typedef enum logic [1:0] {
    ESR_STD_NTSC  = 2'b00,
    ESR_STD_PAL   = 2'b01,
    ESR_STD_SECAM = 2'b10
  } esr_std_t;

  // link slave states
  typedef enum logic [2:0] {
    ESR_IDLE = 3'b000,
    ESR_ADDR = 3'b001,
    ESR_AACK = 3'b010,
    ESR_TX   = 3'b011,
    ESR_MACK = 3'b100
  } esr_link_t;

endpackage

// >>> tb/esr_i2c_master.sv
// esr_i2c_master: behavioural two-wire master reading the status byte
// assumes: sda is the resolved wire with pull-up; scl stands high between frames
`timescale 1ns/1ns
module esr_i2c_master
(
  // two-wire link
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  int         q = 24; // quarter bit time, slow reads raise it
  logic [7:0] got[$];
  logic       ack;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one clock: data set while low, sampled while high
  task bit_x(input logic b, output logic s);
  begin
    sda_low = !b;
    #q scl = 1'b1;
    #q s = sda;
    #q scl = 1'b0;
    #q;
  end
  endtask
  // full read frame of n bytes
  task rd(input logic [7:0] a, input int n);
    logic       s;
    logic [7:0] d;
  begin
    got.delete();
    #q sda_low = 1'b1; // start condition
    #q scl = 1'b0;
    #q;
    for (int i = 7; i >= 0; i--)
      bit_x(a[i], s);
    bit_x(1'b1, s);
    ack = !s;
    for (int k = 0; k < n && ack; k++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        bit_x(1'b1, s);
        d = {d[6:0], s};
      end
      got.push_back(d);
      bit_x(k == n - 1, s);
    end
    sda_low = 1'b1;
    #q scl = 1'b1;
    #q sda_low = 1'b0;
    #(4 * q);
  end
  endtask
endmodule

// >>> tb/esr_status_asserts.sv
// esr_status_asserts: port checks of status byte and read slave
// assumes: bound to esr_status_top, nrst is the raw reset
`timescale 1ns/1ns
module esr_status_asserts
  import esr_pkg::*;
#(
  parameter logic [2:0] VERSION_ID = ESR_VERSION_DEF
)
(
  // clocks and reset
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       lclk,
  // encoder side
  input wire logic       field_start,
  input wire logic       field_is_even,
  input wire logic [1:0] video_std,
  input wire logic       odd_cc_encoded,
  input wire logic       even_cc_encoded,
  input wire logic       odd_cc_written,
  input wire logic       even_cc_written,
  // link and status
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic [7:0] status_byte
);
  logic [2:0] rel_ff;
  logic [2:0] nxt_rel;
  logic [3:0] fld_ff;
  logic [3:0] nxt_fld;
  logic [3:0] seq_len;
  logic       ok;
  // release counter and mirror of the sequence position
  always_comb
  begin
    nxt_rel = (rel_ff == 3'h7) ? rel_ff : rel_ff + 3'h1;
    seq_len = (video_std == 2'b01) ? ESR_SEQ_PAL :
              (video_std == 2'b10) ? ESR_SEQ_SECAM : ESR_SEQ_NTSC;
    nxt_fld = fld_ff;
    if (field_start)
      nxt_fld = (fld_ff + 4'h1 >= seq_len) ? ESR_CNT_RST : fld_ff + 4'h1;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rel_ff <= 3'h0;
      fld_ff <= ESR_CNT_RST;
    end
    else
    begin
      rel_ff <= nxt_rel;
      fld_ff <= nxt_fld;
    end
  end
  assign ok = (rel_ff == 3'h7);
  a_version_bits: assert property (@(posedge clk) disable iff (!nrst)
    ok |-> status_byte[7:5] == VERSION_ID) else $error("version field wrong");
  a_unused_zero: assert property (@(posedge clk) disable iff (!nrst)
    ok |-> status_byte[2] == ESR_UNUSED_VAL) else $error("unused bit set");
  a_odd_set: assert property (@(posedge clk) disable iff (!nrst)
    ok && odd_cc_encoded |-> ##2 status_byte[4]) else $error("odd done not set");
  a_odd_clear: assert property (@(posedge clk) disable iff (!nrst)
    ok && odd_cc_written && !odd_cc_encoded |-> ##2 !status_byte[4])
    else $error("odd done not cleared");
  a_even_set: assert property (@(posedge clk) disable iff (!nrst)
    ok && even_cc_encoded |-> ##2 status_byte[3]) else $error("even done not set");
  a_even_clear: assert property (@(posedge clk) disable iff (!nrst)
    ok && even_cc_written && !even_cc_encoded |-> ##2 !status_byte[3])
    else $error("even done not cleared");
  a_parity_follow: assert property (@(posedge clk) disable iff (!nrst)
    ok |-> status_byte[0] == $past(field_is_even, 2)) else $error("parity bit wrong");
  a_first_field: assert property (@(posedge clk) disable iff (!nrst)
    ok |-> status_byte[1] == $past(fld_ff == ESR_CNT_RST, 2)) else $error("sequence bit wrong");
  a_drain_only: assert property (@(posedge lclk) disable iff (!nrst)
    sda_o == 1'b0) else $error("data pin driven high");
  a_drive_scl_low: assert property (@(posedge lclk) disable iff (!nrst)
    $rose(sda_oe) |-> !scl_i) else $error("data changed with clock high");
endmodule

bind esr_status_top esr_status_asserts #(.VERSION_ID(VERSION_ID)) i_chk (
  .clk(clk), .nrst(nrst), .lclk(lclk), .field_start(field_start),
  .field_is_even(field_is_even), .video_std(video_std), .odd_cc_encoded(odd_cc_encoded),
  .even_cc_encoded(even_cc_encoded), .odd_cc_written(odd_cc_written),
  .even_cc_written(even_cc_written), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .status_byte(status_byte));

// >>> tb/tb.sv
// tb: status byte against a bench model, reads over the two-wire link
// assumes: esr_status_top with checker bound, master model on the link
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb
  import esr_pkg::*;
;
  localparam logic [2:0] VER = 3'h6; // arbitrary value
  logic       clk;
  logic       lclk;
  logic       nrst;
  logic       field_start;
  logic       field_is_even;
  logic [1:0] video_std;
  logic [3:0] cc;
  logic       scl;
  logic       m_low;
  logic       sda_o;
  logic       sda_oe;
  logic       sda;
  logic [7:0] status_byte;
  logic       m_odd;
  logic       m_even;
  int         m_cnt;
  int         m_len;
  int         seed = 24;
  int         tests_run = 0;
  int         n_mismatch = 0;
  // open drain wire with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & !m_low;
  esr_status_top #(.VERSION_ID(VER)) i_dut (.clk(clk), .nrst(nrst), .lclk(lclk),
    .field_start(field_start), .field_is_even(field_is_even), .video_std(video_std),
    .odd_cc_encoded(cc[3]), .even_cc_encoded(cc[2]), .odd_cc_written(cc[1]),
    .even_cc_written(cc[0]), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .status_byte(status_byte));
  esr_i2c_master i_mst (.scl(scl), .sda_low(m_low), .sda(sda));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #1;
    forever #3 lclk = ~lclk;
  end
  function automatic logic [7:0] model();
    return {VER, m_odd, m_even, 1'b0, m_cnt == 0, field_is_even};
  endfunction
  // one cycle of event pulses, then compare
  task step(input logic [5:0] r);
  begin
    @(negedge clk);
    {field_is_even, field_start, cc} = r;
    if (r[1]) m_odd = 1'b0;
    if (r[0]) m_even = 1'b0;
    if (r[3]) m_odd = 1'b1;
    if (r[2]) m_even = 1'b1;
    if (r[4]) m_cnt = (m_cnt + 1 >= m_len) ? 0 : m_cnt + 1;
    @(negedge clk);
    {field_start, cc} = 5'h0;
    repeat (2) @(negedge clk);
    `CHK("status", model(), status_byte)
  end
  endtask
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    nrst = 1'b0;
    {field_is_even, field_start, cc} = 6'h0;
    video_std = 2'b00;
    {m_odd, m_even, m_cnt, m_len} = {2'b00, 32'd0, 32'd4};
    repeat (16) @(posedge clk);
    `CHK("rst status", 8'h00, status_byte)
    @(negedge clk) nrst = 1'b1;
    repeat (4) @(negedge clk);
    for (int s = 0; s < 4; s++)
    begin
      while (m_cnt != 0)
        step(6'h10);
      video_std = 2'(s);
      m_len = (s == 1) ? 8 : (s == 2) ? 12 : 4;
      repeat (40) step(6'($random(seed)));
    end
    repeat (20) @(negedge clk);
    i_mst.rd(ESR_RD_ADDR, 2);
    `CHK("ack", 1'b1, i_mst.ack)
    `CHK("byte0", model(), i_mst.got[0])
    `CHK("byte1", model(), i_mst.got[1])
    step(6'h2a);
    repeat (20) @(negedge clk);
    i_mst.q = 40;
    i_mst.rd(ESR_RD_ADDR, 1);
    `CHK("slow byte", model(), i_mst.got[0])
    i_mst.rd(8'h88, 1);
    `CHK("write nak", 1'b0, i_mst.ack)
    stop_test();
  end
endmodule
